/* hdl/qss_pkg.sv */
package qss_pkg;
    // Register indices on the register port.
    localparam logic [2:0] REG_MODE  = 3'h0;
    localparam logic [2:0] REG_DELAY = 3'h1;
    localparam logic [2:0] REG_WRAP  = 3'h2;
    localparam logic [2:0] REG_IRQ   = 3'h3;
    localparam logic [2:0] REG_ADDR  = 3'h4;
    localparam logic [2:0] REG_DATA  = 3'h5;

    // Field positions in the serial mode register.
    localparam int MODE_BAUD_LSB  = 0;
    localparam int MODE_PHASE_BIT = 8;
    localparam int MODE_IDLE_BIT  = 9;
    localparam int MODE_BITS_LSB  = 10;

    // Field positions in the transfer delay register.
    localparam int DLY_AFTER_LSB  = 0;
    localparam int DLY_EDGE_LSB   = 8;
    localparam int DLY_ENABLE_BIT = 15;

    // Field positions in the queue wrap register.
    localparam int WRAP_NEWQ_LSB = 0;
    localparam int WRAP_CPTQ_LSB = 4;
    localparam int WRAP_ENDQ_LSB = 8;
    localparam int WRAP_SELECT_INACTIVE_LEVEL_BIT = 12;
    localparam int WRAP_WRAPAROUND_ENABLE_BIT = 14;

    // Field positions in the serial interrupt register.
    localparam int IRQ_FLAG_BIT = 0;
    localparam int IRQ_EN_BIT   = 8;

    // Command byte as stored: data port bits 15..8 land in bits 7..0.
    localparam int CMD_HOLD_BIT = 7;
    localparam int CMD_LEN_BIT  = 6;
    localparam int CMD_DT_BIT   = 5;
    localparam int CMD_SELECT_TO_CLOCK_DELAY_SELECT_BIT = 4;
    localparam int CMD_CS_LSB   = 0;

    // Indirect address segments.
    localparam logic [1:0] SEG_TX  = 2'h0;
    localparam logic [1:0] SEG_RX  = 2'h1;
    localparam logic [1:0] SEG_CMD = 2'h2;

    // Values after reset.
    localparam logic [15:0] MODE_RST  = 16'h0004;
    localparam logic [14:0] DELAY_RST = 15'h0000;
    localparam logic [3:0]  QPTR_RST  = 4'h0;

    // Lengths in bits, delays in bus clock cycles.
    localparam logic [4:0]  LEN_DEFAULT   = 5'h08;
    localparam logic [4:0]  LEN_MAX       = 5'h10;
    localparam logic [13:0] STD_AFTER_CYC = 14'h0011;
    localparam int          AFTER_SHIFT   = 5;
    localparam int          AFTER_ZERO_CYC = 8192;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_LOAD  = 3'b001,
        ST_LEAD  = 3'b010,
        ST_SHIFT = 3'b011,
        ST_TRAIL = 3'b100,
        ST_AFTER = 3'b101
    } qss_state_e;
endpackage

/* hdl/qss_sequencer.sv */
`timescale 1ns/10ps
`default_nettype none

module qss_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    wire              do_wr = in_valid & in_ready;
    wire              do_rd = out_valid & out_ready;

    assign in_ready  = (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]) | (wr_ptr[AW] == rd_ptr[AW]);
    assign out_valid = wr_ptr != rd_ptr;
    assign out_data  = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= wr_ptr + (AW+1)'(do_wr);
            rd_ptr <= rd_ptr + (AW+1)'(do_rd);
        end
    end
endmodule

module qss_sequencer #(
    parameter int AFTER_ZERO = qss_pkg::AFTER_ZERO_CYC,
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        reg_req,
    input  wire logic        reg_we,
    input  wire logic [2:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    output logic             reg_ack,
    output logic             sck,
    output logic             mosi,
    input  wire logic        miso,
    output logic      [3:0]  peripheral_select_pins,
    output logic             irq
);
    // Local store: sixteen entries of command, transmit and receive data.
    logic [7:0]  cmd_ram [16];
    logic [15:0] tx_ram  [16];
    logic [15:0] rx_ram  [16];

    logic [15:0] serial_mode_register;
    logic [14:0] delay_cfg;
    logic        run_en;
    logic [3:0]  new_queue_pointer;
    logic [3:0]  completed_queue_pointer;
    logic [3:0]  end_queue_pointer;
    logic        select_inactive_level;
    logic        wraparound_enable;
    logic        queue_finished_flag;
    logic        finished_interrupt_enable;
    logic [5:0]  indirect_address_pointer;

    qss_pkg::qss_state_e state;
    logic [3:0]  cur_ptr;
    logic        newq_pend;
    logic [7:0]  cur_cmd;
    logic [15:0] tx_sh;
    logic [15:0] rx_sh;
    logic [4:0]  len;
    logic [4:0]  edges;
    logic [13:0] tmr;
    logic        stopping;
    logic        push;
    logic [19:0] push_data;
    logic        miso_m;
    logic        miso_s;

    // Host decode.
    wire        host_wr    = reg_req & reg_we;
    wire        host_rd    = reg_req & ~reg_we;
    wire        data_acc   = reg_req & (reg_addr == qss_pkg::REG_DATA);
    wire [1:0]  seg        = indirect_address_pointer[5:4];
    wire [3:0]  idx        = indirect_address_pointer[3:0];
    wire        tx_we      = host_wr & data_acc & (seg == qss_pkg::SEG_TX);
    wire        cmd_we     = host_wr & data_acc & (seg == qss_pkg::SEG_CMD);
    wire        rx_rd      = host_rd & data_acc & (seg == qss_pkg::SEG_RX);
    wire        wr_mode    = host_wr & (reg_addr == qss_pkg::REG_MODE);
    wire        wr_delay   = host_wr & (reg_addr == qss_pkg::REG_DELAY);
    wire        wr_wrap    = host_wr & (reg_addr == qss_pkg::REG_WRAP);
    wire        wr_irq     = host_wr & (reg_addr == qss_pkg::REG_IRQ);
    wire        wr_addr    = host_wr & (reg_addr == qss_pkg::REG_ADDR);

    // Mode and delay fields.
    wire [7:0]  baud       = serial_mode_register[qss_pkg::MODE_BAUD_LSB +: 8];
    wire        phase      = serial_mode_register[qss_pkg::MODE_PHASE_BIT];
    wire        idle_lvl   = serial_mode_register[qss_pkg::MODE_IDLE_BIT];
    wire [3:0]  bits_fld   = serial_mode_register[qss_pkg::MODE_BITS_LSB +: 4];
    wire [7:0]  after_transfer_delay_count = delay_cfg[qss_pkg::DLY_AFTER_LSB +: 8];
    wire [6:0]  select_to_edge_delay_count = delay_cfg[qss_pkg::DLY_EDGE_LSB +: 7];
    wire [13:0] half_cyc   = (baud == 8'h00) ? 14'h0000 : {6'h00, baud} - 14'h0001;

    // Entry about to be loaded.
    wire [7:0]  ld_cmd     = cmd_ram[cur_ptr];
    wire        length_select = ld_cmd[qss_pkg::CMD_LEN_BIT];
    wire [4:0]  mode_len   = (bits_fld == 4'h0) ? qss_pkg::LEN_MAX
                           : (bits_fld < 4'h8) ? qss_pkg::LEN_DEFAULT : {1'b0, bits_fld};
    wire [4:0]  ld_len     = length_select ? mode_len : qss_pkg::LEN_DEFAULT;
    wire [4:0]  just       = 5'(qss_pkg::LEN_MAX - ld_len);
    wire [15:0] ld_sh      = tx_ram[cur_ptr] << just;
    wire        select_to_clock_delay_select = ld_cmd[qss_pkg::CMD_SELECT_TO_CLOCK_DELAY_SELECT_BIT];
    wire [13:0] lead_cyc   = (select_to_clock_delay_select && select_to_edge_delay_count != 7'h00)
                           ? {7'h00, select_to_edge_delay_count} - 14'h0001
                           : half_cyc;

    // Commands of the running entry.
    wire        hold_select_across_queue   = cur_cmd[qss_pkg::CMD_HOLD_BIT];
    wire        post_transfer_delay_select = cur_cmd[qss_pkg::CMD_DT_BIT];
    wire [13:0] after_cyc  = !post_transfer_delay_select ? qss_pkg::STD_AFTER_CYC
                           : (after_transfer_delay_count == 8'h00) ? 14'(AFTER_ZERO)
                           : {1'b0, after_transfer_delay_count, 5'h00};

    // Shift timing.
    wire        tick       = tmr == 14'h0000;
    wire        edge_now   = (state == qss_pkg::ST_SHIFT) & tick & (baud != 8'h00);
    wire        sample     = ~edges[0] ^ phase;
    wire [4:0]  last_edge  = 5'({len, 1'b0} - 6'h01);
    wire        at_end     = end_queue_pointer == cur_ptr;
    wire        finish     = (state == qss_pkg::ST_TRAIL) & tick;
    wire        stop_now   = finish & ((at_end & ~wraparound_enable) | ~run_en);
    wire        go         = (state == qss_pkg::ST_IDLE) & run_en;

    // Receive words pass the FIFO on their way to receive storage.
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic [19:0] fifo_out_data;
    wire         fifo_out_ready = ~rx_rd;

    qss_fifo #(
        .WIDTH (20),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .clk       (clk),
        .rst_b     (rst_b),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   (push_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // Read selection.
    wire [15:0] wrap_view  = {1'b0, wraparound_enable, 1'b0, select_inactive_level,
                              end_queue_pointer, completed_queue_pointer,
                              new_queue_pointer};
    wire [15:0] irq_view   = {7'h00, finished_interrupt_enable, 7'h00, queue_finished_flag};
    wire [15:0] data_view  = (seg == qss_pkg::SEG_RX) ? rx_ram[idx] : 16'h0000;
    wire [15:0] next_rdata = (reg_addr == qss_pkg::REG_MODE)  ? serial_mode_register
                           : (reg_addr == qss_pkg::REG_DELAY) ? {run_en, delay_cfg}
                           : (reg_addr == qss_pkg::REG_WRAP)  ? wrap_view
                           : (reg_addr == qss_pkg::REG_IRQ)   ? irq_view
                           : (reg_addr == qss_pkg::REG_ADDR)  ? {10'h000, indirect_address_pointer}
                           : (reg_addr == qss_pkg::REG_DATA)  ? data_view
                           : 16'h0000;

    assign irq = queue_finished_flag & finished_interrupt_enable;

    // Storage writes. Only the host port writes command bytes.
    always_ff @(posedge clk) begin
        if (cmd_we) begin
            cmd_ram[idx] <= reg_wdata[15:8];
        end
        if (tx_we) begin
            tx_ram[idx] <= reg_wdata;
        end
        if (fifo_out_valid && fifo_out_ready) begin
            rx_ram[fifo_out_data[19:16]] <= fifo_out_data[15:0];
        end
    end

    // Register port: every access is answered one cycle later.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_ack   <= 1'b0;
            reg_rdata <= 16'h0000;
        end else begin
            reg_ack   <= reg_req;
            reg_rdata <= host_rd ? next_rdata : 16'h0000;
        end
    end

    // Miso is asynchronous to clk and is only read after the second flop.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            miso_m <= 1'b0;
            miso_s <= 1'b0;
        end else begin
            miso_m <= miso;
            miso_s <= miso_m;
        end
    end

    // Software registers.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            serial_mode_register      <= qss_pkg::MODE_RST;
            delay_cfg                 <= qss_pkg::DELAY_RST;
            run_en                    <= 1'b0;
            new_queue_pointer         <= qss_pkg::QPTR_RST;
            end_queue_pointer         <= qss_pkg::QPTR_RST;
            select_inactive_level     <= 1'b1;
            wraparound_enable         <= 1'b0;
            queue_finished_flag       <= 1'b0;
            finished_interrupt_enable <= 1'b0;
            indirect_address_pointer  <= 6'h00;
        end else begin
            if (wr_mode) begin
                serial_mode_register <= reg_wdata;
            end
            if (wr_delay) begin
                delay_cfg <= reg_wdata[14:0];
            end
            // The engine's clear on completion outranks a same-cycle software write.
            if (stop_now) begin
                run_en <= 1'b0;
            end else if (wr_delay) begin
                run_en <= reg_wdata[qss_pkg::DLY_ENABLE_BIT];
            end
            if (wr_wrap) begin
                new_queue_pointer     <= reg_wdata[qss_pkg::WRAP_NEWQ_LSB +: 4];
                end_queue_pointer     <= reg_wdata[qss_pkg::WRAP_ENDQ_LSB +: 4];
                select_inactive_level <= reg_wdata[qss_pkg::WRAP_SELECT_INACTIVE_LEVEL_BIT];
                wraparound_enable     <= reg_wdata[qss_pkg::WRAP_WRAPAROUND_ENABLE_BIT];
            end
            // A completion in the same cycle as a clear keeps the flag set.
            if (finish && at_end) begin
                queue_finished_flag <= 1'b1;
            end else if (wr_irq && reg_wdata[qss_pkg::IRQ_FLAG_BIT]) begin
                queue_finished_flag <= 1'b0;
            end
            if (wr_irq) begin
                finished_interrupt_enable <= reg_wdata[qss_pkg::IRQ_EN_BIT];
            end
            if (wr_addr) begin
                indirect_address_pointer <= reg_wdata[5:0];
            end else if (data_acc) begin
                indirect_address_pointer <= indirect_address_pointer + 6'h01;
            end
        end
    end

    // Queue pointers.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cur_ptr                 <= qss_pkg::QPTR_RST;
            completed_queue_pointer <= qss_pkg::QPTR_RST;
            newq_pend               <= 1'b0;
        end else if (finish) begin
            completed_queue_pointer <= cur_ptr;
            cur_ptr   <= (newq_pend | wr_wrap) ? (wr_wrap ? reg_wdata[3:0] : new_queue_pointer)
                                               : cur_ptr + 4'h1;
            newq_pend <= 1'b0;
        end else if (state == qss_pkg::ST_IDLE) begin
            cur_ptr   <= wr_wrap ? reg_wdata[3:0] : new_queue_pointer;
            newq_pend <= 1'b0;
        end else if (wr_wrap) begin
            newq_pend <= 1'b1;
        end
    end

    // Queue engine. Entry settings are latched at load and held to the end.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state                  <= qss_pkg::ST_IDLE;
            cur_cmd                <= 8'h0F;
            tx_sh                  <= 16'h0000;
            rx_sh                  <= 16'h0000;
            len                    <= qss_pkg::LEN_DEFAULT;
            edges                  <= 5'h00;
            tmr                    <= 14'h0000;
            stopping               <= 1'b0;
            push                   <= 1'b0;
            push_data              <= 20'h00000;
            sck                    <= 1'b0;
            mosi                   <= 1'b0;
            peripheral_select_pins <= 4'hF;
        end else begin
            push <= 1'b0;
            if (!tick) begin
                tmr <= tmr - 14'h0001;
            end
            unique case (state)
                qss_pkg::ST_IDLE: begin
                    sck                    <= idle_lvl;
                    peripheral_select_pins <= {4{select_inactive_level}};
                    if (go) begin
                        state <= qss_pkg::ST_LOAD;
                    end
                end
                qss_pkg::ST_LOAD: begin
                    // Waiting for FIFO room stalls the queue until receive data drains.
                    if (fifo_in_ready) begin
                        cur_cmd                <= ld_cmd;
                        len                    <= ld_len;
                        peripheral_select_pins <= ld_cmd[qss_pkg::CMD_CS_LSB +: 4];
                        tx_sh                  <= phase ? ld_sh : {ld_sh[14:0], 1'b0};
                        mosi                   <= ld_sh[15];
                        rx_sh                  <= 16'h0000;
                        edges                  <= 5'h00;
                        tmr                    <= lead_cyc;
                        state                  <= qss_pkg::ST_LEAD;
                    end
                end
                qss_pkg::ST_LEAD: begin
                    if (tick) begin
                        state <= qss_pkg::ST_SHIFT;
                    end
                end
                qss_pkg::ST_SHIFT: begin
                    if (edge_now) begin
                        sck   <= ~sck;
                        edges <= edges + 5'h01;
                        tmr   <= half_cyc;
                        if (sample) begin
                            rx_sh <= {rx_sh[14:0], miso_s};
                        end else begin
                            mosi  <= tx_sh[15];
                            tx_sh <= {tx_sh[14:0], 1'b0};
                        end
                        if (edges == last_edge) begin
                            state <= qss_pkg::ST_TRAIL;
                        end
                    end
                end
                qss_pkg::ST_TRAIL: begin
                    if (tick) begin
                        push      <= 1'b1;
                        push_data <= {cur_ptr, rx_sh};
                        stopping  <= stop_now;
                        tmr       <= after_cyc - 14'h0001;
                        state     <= qss_pkg::ST_AFTER;
                        if (stop_now || at_end || !hold_select_across_queue) begin
                            peripheral_select_pins <= {4{select_inactive_level}};
                        end
                    end
                end
                qss_pkg::ST_AFTER: begin
                    if (tick) begin
                        state <= stopping ? qss_pkg::ST_IDLE : qss_pkg::ST_LOAD;
                    end
                end
                default: begin
                    state <= qss_pkg::ST_IDLE;
                end
            endcase
        end
    end
endmodule

`default_nettype wire

/* sim/qss_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module qss_chk (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        reg_req,
    input wire logic        reg_we,
    input wire logic [2:0]  reg_addr,
    input wire logic [15:0] reg_rdata,
    input wire logic        reg_ack,
    input wire logic        sck,
    input wire logic [3:0]  peripheral_select_pins,
    input wire logic        irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_sck_quiet;
        $stable(sck) ##1 $stable(sck);
    endsequence
    sequence s_rd_unmapped;
        reg_req && !reg_we && reg_addr > 3'h5;
    endsequence
    a_ack_one_cycle: assert property (reg_req |=> reg_ack)
        else $error("request without acknowledge");
    a_ack_has_cause: assert property (reg_ack |-> $past(reg_req))
        else $error("acknowledge without request");
    a_rdata_quiet: assert property (!reg_ack |-> reg_rdata == 16'h0000)
        else $error("read data outside acknowledge");
    a_write_rdata_zero: assert property (reg_req && reg_we |=> reg_rdata == 16'h0000)
        else $error("read data on write");
    a_unmapped_reads_zero: assert property (s_rd_unmapped |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_sel_stable_sck: assert property ($changed(peripheral_select_pins) |-> s_sck_quiet)
        else $error("select moved near a clock edge");
    a_irq_fall_cause: assert property ($fell(irq) |->
        $past(reg_req && reg_we && reg_addr == qss_pkg::REG_IRQ))
        else $error("interrupt dropped without write");
    a_sel_reset_idle: assert property ($rose(rst_b) |-> peripheral_select_pins == 4'hF)
        else $error("selects active after reset");
endmodule
bind qss_sequencer qss_chk qss_chk_i (.clk(clk), .rst_b(rst_b), .reg_req(reg_req),
    .reg_we(reg_we), .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .sck(sck), .peripheral_select_pins(peripheral_select_pins), .irq(irq));
`default_nettype wire

/* sim/qss_slave.sv */
`timescale 1ns/10ps
`default_nettype none
module qss_slave (
    input wire logic        clk,
    input wire logic        sck,
    input wire logic        mosi,
    input wire logic        cs_b,
    input wire logic        clock_sample_phase,
    input wire logic [15:0] tx,
    output logic            miso,
    output logic     [15:0] rx
);
    logic        sck_q;
    logic        idle_lvl;
    logic        tog = 1'b0;
    logic [16:0] sh;
    wire         moved = sck != sck_q;
    wire         lead  = moved && sck != idle_lvl;
    // A released line shows a changing pattern, never the last bit.
    assign miso = cs_b ? tog : sh[16];
    always @(posedge clk) begin
        sck_q <= sck;
        tog   <= ~tog;
        if (cs_b) begin
            idle_lvl <= sck;
            sh       <= clock_sample_phase ? {1'b0, tx} : {tx, 1'b0};
        end else if (moved) begin
            if (lead != clock_sample_phase) rx <= {rx[14:0], mosi};
            if (lead == clock_sample_phase) sh <= sh << 1;
        end
    end
endmodule
`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[ERR] t=%0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
    logic        clk = 1'b0, rst_b = 1'b0, reg_req = 1'b0, reg_we = 1'b0, clock_sample_phase = 1'b0;
    logic [2:0]  reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, s_rx, rdv;
    logic        reg_ack, sck, mosi, miso, irq;
    logic [3:0]  sel;
    int          n_xfer = 0, n0, n_mismatch = 0, n_tests = 0;
    always #5 clk = ~clk;
    always @(negedge sel[0]) n_xfer++;
    qss_sequencer #(.AFTER_ZERO(64), .FIFO_DEPTH(8)) qss_sequencer_i (.clk(clk), .rst_b(rst_b),
        .reg_req(reg_req), .reg_we(reg_we), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_ack(reg_ack), .sck(sck), .mosi(mosi), .miso(miso),
        .peripheral_select_pins(sel), .irq(irq));
    qss_slave qss_slave_i (.clk(clk), .sck(sck), .mosi(mosi), .cs_b(sel[0]), .clock_sample_phase(clock_sample_phase),
        .tx(16'h5A00), .miso(miso), .rx(s_rx));
    task automatic acc(input logic [2:0] a, input logic we, input logic [15:0] d);
        reg_req   <= 1'b1;
        reg_we    <= we;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_req <= 1'b0;
        @(posedge clk);
        rdv = reg_rdata;
        `CHK(reg_ack, 1'b1)
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        acc(a, 1'b1, d);
    endtask
    task automatic rc(input logic [2:0] a, input logic [15:0] e);
        acc(a, 1'b0, 16'h0000);
        `CHK(rdv, e)
    endtask
    task automatic go();
        n0 = n_xfer;
        wr(qss_pkg::REG_IRQ, 16'h0101);
        wr(qss_pkg::REG_DELAY, 16'h8300);
        repeat (3000) if (irq !== 1'b1) @(posedge clk);
        `CHK(irq, 1'b1)
    endtask
    task automatic t_reset();
        rc(qss_pkg::REG_MODE, 16'h0004);
        rc(qss_pkg::REG_WRAP, 16'h1000);
        rc(qss_pkg::REG_IRQ, 16'h0000);
        rc(3'h6, 16'h0000);
    endtask
    task automatic t_queue();
        wr(qss_pkg::REG_MODE, 16'h3004);
        wr(qss_pkg::REG_ADDR, 16'h0000);
        wr(qss_pkg::REG_DATA, 16'hA5C3);
        wr(qss_pkg::REG_DATA, 16'h0ABC);
        wr(qss_pkg::REG_ADDR, 16'h0020);
        wr(qss_pkg::REG_DATA, 16'h0E00);
        wr(qss_pkg::REG_DATA, 16'h5E00);
        wr(qss_pkg::REG_WRAP, 16'h1100);
        go();
        rc(qss_pkg::REG_WRAP, 16'h1110);
        rc(qss_pkg::REG_DELAY, 16'h0300);
        `CHK(n_xfer - n0, 2)
        `CHK(s_rx, 16'h3ABC)
        wr(qss_pkg::REG_ADDR, 16'h0010);
        rc(qss_pkg::REG_DATA, 16'h005A);
        rc(qss_pkg::REG_DATA, 16'h05A0);
        wr(qss_pkg::REG_ADDR, 16'h0020);
        rc(qss_pkg::REG_DATA, 16'h0000);
        rc(qss_pkg::REG_IRQ, 16'h0101);
        wr(qss_pkg::REG_IRQ, 16'h0001);
        `CHK(irq, 1'b0)
    endtask
    task automatic t_hold();
        wr(qss_pkg::REG_ADDR, 16'h0020);
        wr(qss_pkg::REG_DATA, 16'h8E00);
        go();
        rc(qss_pkg::REG_WRAP, 16'h1110);
        `CHK(n_xfer - n0, 1)
        `CHK(sel, 4'hF)
    endtask
    task automatic t_single();
        wr(qss_pkg::REG_WRAP, 16'h1101);
        go();
        rc(qss_pkg::REG_WRAP, 16'h1111);
        `CHK(n_xfer - n0, 1)
        `CHK(s_rx[11:0], 12'hABC)
    endtask
    task automatic t_modes();
        wr(qss_pkg::REG_WRAP, 16'h1000);
        for (int m = 0; m < 4; m++) begin
            wr(qss_pkg::REG_MODE, 16'h0004 | 16'(m << 8));
            clock_sample_phase <= m[0];
            go();
            `CHK(n_xfer - n0, 1)
            `CHK(s_rx[7:0], 8'hC3)
            wr(qss_pkg::REG_ADDR, 16'h0010);
            rc(qss_pkg::REG_DATA, 16'h005A);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        summarize();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_reset();
        t_queue();
        t_hold();
        t_single();
        t_modes();
        summarize();
    end
endmodule
`default_nettype wire
